// File: logic/tcbu_regs.svh
// Constants for the trace capture and breakpoint unit
`ifndef TCBU_REGS_SVH
`define TCBU_REGS_SVH
`define TCBU_TRACE_DEPTH   64
`define TCBU_TRACE_WIDTH   16
`define TCBU_FIFO_DEPTH    16
`define TCBU_MODE_NORMAL   2'h0
`define TCBU_MODE_LOOP     2'h1
`define TCBU_MODE_DETAIL   2'h2
`define TCBU_MODE_PROFILE  2'h3
`define TCBU_COF_SOURCE    2'h0
`define TCBU_COF_DEST      2'h1
`define TCBU_COF_VECTOR    2'h2
`define TCBU_CYC_DATA      2'h0
`define TCBU_CYC_PFETCH    2'h1
`define TCBU_CYC_FREE      2'h2
`define TCBU_COUNT_RST     7'h00
`define TCBU_PTR_RST       6'h00
`endif

// File: logic/tcbu_pkg.sv
// Types shared by the trace capture and breakpoint unit
package tcbu_pkg;
	typedef enum logic [1:0] {
		RUN_IDLE  = 2'b00,
		RUN_WAIT  = 2'b01,
		RUN_STORE = 2'b10
	} tcbu_run_e;

	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic        swi_or_dbg;
		logic [15:0] addr;
	} tcbu_cof_s;

	typedef struct packed {
		logic        valid;
		logic [1:0]  cyc;
		logic [15:0] addr;
		logic [15:0] data;
	} tcbu_cycle_s;
endpackage : tcbu_pkg

// File: logic/tcbu_top.sv
// Trace FIFO and the trace capture and breakpoint unit
`timescale 1ns/1ns
`default_nettype none
`include "tcbu_regs.svh"

module tcbu_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_n_i,
	input  wire logic             clk_en_i,
	input  wire logic             flush_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
		$error("tcbu_fifo: DEPTH must be a power of two of at least 2");
	end
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wp_ff;
	logic [AW-1:0]    rp_ff;
	logic [AW:0]      cnt_ff;
	wire              push = in_valid_i & in_ready_o;
	wire              pop  = out_valid_o & out_ready_i;

	assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_ff != '0);
	assign out_data_o  = mem_ff[rp_ff];

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i || (clk_en_i && flush_i)) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
		end else if (clk_en_i) begin
			if (push) begin
				mem_ff[wp_ff] <= in_data_i;
				wp_ff         <= wp_ff + 1'b1;
			end
			if (pop)
				rp_ff <= rp_ff + 1'b1;
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : tcbu_fifo

module tcbu_top #(
	parameter int DEPTH      = `TCBU_TRACE_DEPTH,
	parameter int FIFO_DEPTH = `TCBU_FIFO_DEPTH
) (
	input  wire logic                sys_clk_i,
	input  wire logic                rst_n_i,
	input  wire logic                clk_en_i,
	input  wire logic                debug_enable_i,
	input  wire logic                arm_i,
	input  wire logic                disarm_i,
	input  wire logic                begin_sel_i,
	input  wire logic                event_only_i,
	input  wire logic [1:0]          capture_mode_i,
	input  wire logic                trigger_select_i,
	input  wire logic                ab_breakpoint_enable_i,
	input  wire logic                c_breakpoint_enable_i,
	input  wire logic                c_breakpoint_type_i,
	input  wire logic                trigger_i,
	input  wire logic                comp_c_match_i,
	input  wire tcbu_pkg::tcbu_cof_s   cof_i,
	input  wire tcbu_pkg::tcbu_cycle_s cycle_i,
	input  wire logic [15:0]         last_instr_addr_i,
	input  wire logic                trace_read_i,
	input  wire logic                ext_tag_high_pin_i,
	input  wire logic                ext_tag_low_pin_i,
	output logic                     armed_o,
	output logic [6:0]               valid_word_count_o,
	output logic [15:0]              trace_data_o,
	output logic                     trace_data_valid_o,
	output logic                     capture_ready_o,
	output logic [15:0]              comp_c_addr_o,
	output logic                     comp_c_ignore_o,
	output logic                     brk_req_o,
	output logic                     brk_tagged_o
);
	if (DEPTH != 64) begin : g_depth_chk
		$error("tcbu_top: counters and pointers are sized for 64 words");
	end

	tcbu_pkg::tcbu_run_e run_ff;
	tcbu_pkg::tcbu_run_e nxt_run;
	logic        armed_ff;
	logic [15:0] ram_ff [DEPTH];
	logic [5:0]  wr_ptr_ff;
	logic [5:0]  rd_off_ff;
	logic [6:0]  count_ff;
	logic [6:0]  enq_cnt_ff;
	logic [15:0] pend_data_ff;
	logic        pend_ff;
	logic [15:0] comp_c_ff;
	logic        c_ign_ff;
	logic [15:0] rdata_ff;
	logic        rvalid_ff;
	logic        cap_rdy_ff;
	logic        brk_ff;
	logic        brk_tag_ff;
	logic [1:0]  tag_hi_sync_ff;
	logic [1:0]  tag_lo_sync_ff;

	// Mode decoding
	wire mode_loop    = (capture_mode_i == `TCBU_MODE_LOOP);
	wire mode_detail  = (capture_mode_i == `TCBU_MODE_DETAIL);
	wire mode_profile = (capture_mode_i == `TCBU_MODE_PROFILE);
	wire ev_only      = event_only_i & ~mode_detail;
	wire eff_begin    = begin_sel_i | ev_only;
	wire armed        = (run_ff != tcbu_pkg::RUN_IDLE);
	wire arm_go       = arm_i & debug_enable_i & ~mode_profile;

	// Storing window: begin waits for trigger and includes its entry, end stops before it
	wire trig_begin = (run_ff == tcbu_pkg::RUN_WAIT) & trigger_i;
	wire trig_end   = (run_ff == tcbu_pkg::RUN_STORE) & ~eff_begin & trigger_i;
	wire store_win  = ((run_ff == tcbu_pkg::RUN_STORE) & ~trig_end) | trig_begin;
	wire room       = (enq_cnt_ff < 7'(DEPTH)) | ~eff_begin;

	// Word selection per capture mode
	wire cof_take  = cof_i.valid & ~(cof_i.kind == `TCBU_COF_VECTOR & cof_i.swi_or_dbg);
	wire loop_dup  = mode_loop & c_ign_ff & (cof_i.kind == `TCBU_COF_SOURCE)
	               & (cof_i.addr == comp_c_ff);
	wire cyc_take  = cycle_i.valid & (cycle_i.cyc != `TCBU_CYC_PFETCH)
	               & (cycle_i.cyc != `TCBU_CYC_FREE);
	wire sel_valid = mode_detail ? cyc_take
	               : ev_only ? trigger_i
	               : (cof_take & ~loop_dup);
	wire [15:0] sel_word = mode_detail ? cycle_i.addr
	                     : ev_only ? cycle_i.data : cof_i.addr;

	// A held detail data word goes first so address and data stay in order
	wire        f_in_rdy;
	wire        f_out_vld;
	wire [15:0] f_out_data;
	wire        want_new  = store_win & room & sel_valid & ~mode_profile;
	wire        f_in_vld  = pend_ff | want_new;
	wire [15:0] f_in_data = pend_ff ? pend_data_ff : sel_word;
	wire        new_taken = want_new & ~pend_ff & f_in_rdy;

	// Readout stalls the drain for a cycle; the FIFO absorbs it
	wire f_out_rdy = ~trace_read_i;
	wire ram_wr    = f_out_vld & f_out_rdy;
	wire full_now  = ram_wr & (count_ff == 7'(DEPTH - 1));

	tcbu_fifo #(
		.WIDTH(`TCBU_TRACE_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i  (sys_clk_i),
		.rst_n_i    (rst_n_i),
		.clk_en_i   (clk_en_i),
		.flush_i    (arm_go),
		.in_valid_i (f_in_vld),
		.in_ready_o (f_in_rdy),
		.in_data_i  (f_in_data),
		.out_valid_o(f_out_vld),
		.out_ready_i(f_out_rdy),
		.out_data_o (f_out_data)
	);

	// Oldest word sits count words behind the write pointer
	wire [5:0] rd_addr = wr_ptr_ff - count_ff[5:0] + rd_off_ff;
	wire       rd_ok   = debug_enable_i & ~armed;

	// Run state machine
	always_comb begin
		nxt_run = run_ff;
		case (run_ff)
			tcbu_pkg::RUN_IDLE: begin
				if (arm_go)
					nxt_run = eff_begin ? tcbu_pkg::RUN_WAIT : tcbu_pkg::RUN_STORE;
			end
			tcbu_pkg::RUN_WAIT: begin
				if (trig_begin)
					nxt_run = tcbu_pkg::RUN_STORE;
			end
			tcbu_pkg::RUN_STORE: begin
				if (trig_end || (eff_begin && full_now))
					nxt_run = tcbu_pkg::RUN_IDLE;
			end
			default: nxt_run = tcbu_pkg::RUN_IDLE;
		endcase
		if (disarm_i || !debug_enable_i || mode_profile)
			nxt_run = tcbu_pkg::RUN_IDLE;
	end

	// Breakpoint sources
	wire ab_end  = ab_breakpoint_enable_i & trig_end;
	wire ab_full = ab_breakpoint_enable_i & eff_begin & full_now & armed;
	wire c_brk   = c_breakpoint_enable_i & comp_c_match_i & ~mode_loop;
	wire dbg_brk = debug_enable_i & ~mode_profile & (ab_end | ab_full | c_brk);
	wire ext_brk = ~debug_enable_i & (tag_hi_sync_ff[1] | tag_lo_sync_ff[1]);
	// End run tags per select, full buffer always forced, C uses its own type
	wire dbg_tag = ab_end ? trigger_select_i
	             : ab_full ? 1'b0
	             : c_breakpoint_type_i;

	// Reset only clears debug state; no reset request leaves this unit
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			run_ff   <= tcbu_pkg::RUN_IDLE;
			armed_ff <= 1'b0;
		end else if (clk_en_i) begin
			run_ff   <= nxt_run;
			armed_ff <= (nxt_run != tcbu_pkg::RUN_IDLE);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			tag_hi_sync_ff <= 2'h0;
			tag_lo_sync_ff <= 2'h0;
		end else if (clk_en_i) begin
			tag_hi_sync_ff <= {tag_hi_sync_ff[0], ext_tag_high_pin_i};
			tag_lo_sync_ff <= {tag_lo_sync_ff[0], ext_tag_low_pin_i};
		end
	end

	// Capture write port, circular
	always_ff @(posedge sys_clk_i) begin
		if (ram_wr && clk_en_i)
			ram_ff[wr_ptr_ff] <= f_out_data;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_ff <= `TCBU_PTR_RST;
			count_ff  <= `TCBU_COUNT_RST;
		end else if (clk_en_i) begin
			if (ram_wr)
				wr_ptr_ff <= wr_ptr_ff + 6'h01;
			if (arm_go)
				count_ff <= `TCBU_COUNT_RST;
			else if (ram_wr && count_ff != 7'(DEPTH))
				count_ff <= count_ff + 7'h01;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			enq_cnt_ff   <= `TCBU_COUNT_RST;
			pend_ff      <= 1'b0;
			pend_data_ff <= 16'h0000;
		end else if (clk_en_i) begin
			if (arm_go)
				enq_cnt_ff <= `TCBU_COUNT_RST;
			else if (f_in_vld && f_in_rdy && enq_cnt_ff != 7'h7f)
				enq_cnt_ff <= enq_cnt_ff + 7'h01;
			if (arm_go)
				pend_ff <= 1'b0;
			else if (pend_ff && f_in_rdy)
				pend_ff <= 1'b0;
			else if (new_taken && mode_detail) begin
				pend_ff      <= 1'b1;
				pend_data_ff <= cycle_i.data;
			end
		end
	end

	// Comparator C holds the last stored address in loop mode
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			comp_c_ff <= 16'h0000;
			c_ign_ff  <= 1'b0;
		end else if (clk_en_i) begin
			if (arm_go && mode_loop) begin
				comp_c_ff <= 16'h0000;
				c_ign_ff  <= 1'b0;
			end else if (new_taken && mode_loop) begin
				comp_c_ff <= sel_word;
				c_ign_ff  <= 1'b1;
			end
		end
	end

	// Read port; profile reads bypass the memory
	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rd_off_ff <= `TCBU_PTR_RST;
			rdata_ff  <= 16'h0000;
			rvalid_ff <= 1'b0;
		end else if (clk_en_i) begin
			rvalid_ff <= 1'b0;
			if (arm_go)
				rd_off_ff <= `TCBU_PTR_RST;
			if (trace_read_i) begin
				if (mode_profile) begin
					rdata_ff  <= last_instr_addr_i;
					rvalid_ff <= 1'b1;
				end else if (rd_ok) begin
					rdata_ff  <= ram_ff[rd_addr];
					rvalid_ff <= 1'b1;
					rd_off_ff <= rd_off_ff + 6'h01;
				end else begin
					rdata_ff  <= 16'h0000;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			brk_ff     <= 1'b0;
			brk_tag_ff <= 1'b0;
			cap_rdy_ff <= 1'b0;
		end else if (clk_en_i) begin
			brk_ff     <= dbg_brk | ext_brk;
			brk_tag_ff <= dbg_brk ? dbg_tag : ext_brk;
			cap_rdy_ff <= f_in_rdy & ~pend_ff;
		end
	end

	assign armed_o            = armed_ff;
	assign valid_word_count_o = count_ff;
	assign trace_data_o       = rdata_ff;
	assign trace_data_valid_o = rvalid_ff;
	assign capture_ready_o    = cap_rdy_ff;
	assign comp_c_addr_o      = comp_c_ff;
	assign comp_c_ignore_o    = c_ign_ff;
	assign brk_req_o          = brk_ff;
	assign brk_tagged_o       = brk_tag_ff;
endmodule : tcbu_top
`default_nettype wire

// File: tb/tcbu_cpu_model.sv
// Behavioural CPU core that offers change-of-flow records to the unit
`timescale 1ns/1ns
`default_nettype none
module tcbu_cpu_model (
	input  wire logic           sys_clk_i,
	input  wire logic           req_i,
	input  wire logic [1:0]     kind_i,
	input  wire logic           swi_i,
	input  wire logic [15:0]    addr_i,
	input  wire logic           ready_i,
	output var tcbu_pkg::tcbu_cof_s cof_o
);
	initial cof_o = '0;
	// An idle bus inverts the address again on every idle cycle and drives valid low, so a stale record never looks valid
	always @(posedge sys_clk_i) begin
		cof_o.valid <= req_i && ready_i;
		if (req_i && ready_i) begin
			cof_o.kind <= kind_i;
			cof_o.swi_or_dbg <= swi_i;
			cof_o.addr <= addr_i;
		end else begin
			cof_o.addr <= ~cof_o.addr;
		end
	end
endmodule : tcbu_cpu_model
`default_nettype wire

// File: tb/tcbu_properties.sv
// Concurrent checks on the ports of the trace capture and breakpoint unit
`timescale 1ns/1ns
`default_nettype none
module tcbu_checker (
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	input wire logic       clk_en_i,
	input wire logic       debug_enable_i,
	input wire logic       arm_i,
	input wire logic       begin_sel_i,
	input wire logic       event_only_i,
	input wire logic [1:0] capture_mode_i,
	input wire logic       trigger_select_i,
	input wire logic       ab_breakpoint_enable_i,
	input wire logic       c_breakpoint_enable_i,
	input wire logic       c_breakpoint_type_i,
	input wire logic       trigger_i,
	input wire logic       comp_c_match_i,
	input wire logic       trace_read_i,
	input wire logic       armed_o,
	input wire logic [6:0] valid_word_count_o,
	input wire logic       trace_data_valid_o,
	input wire logic       brk_req_o,
	input wire logic       brk_tagged_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	wire run = clk_en_i && debug_enable_i && capture_mode_i != 2'h3;
	wire end_hit = run && armed_o && trigger_i && !begin_sel_i && !event_only_i && !arm_i;
	AST_RESET_IDLE: assert property (
		$rose(rst_n_i) |-> !armed_o && !brk_req_o && valid_word_count_o == 7'h00)
		else $error("unit not idle after reset");
	AST_PROFILE_NO_BRK: assert property (
		(debug_enable_i && capture_mode_i == 2'h3) [*2] |-> !brk_req_o)
		else $error("breakpoint in profile mode");
	AST_ARMED_READ: assert property (
		armed_o && trace_read_i && capture_mode_i != 2'h3 |=> !trace_data_valid_o)
		else $error("readout valid while armed");
	AST_COUNT_KEEP: assert property (
		!arm_i |=> valid_word_count_o >= $past(valid_word_count_o))
		else $error("word count dropped");
	AST_COUNT_MAX: assert property (
		valid_word_count_o <= 7'h40)
		else $error("word count above depth");
	AST_ARM_CLEAR: assert property (
		run && arm_i |=> armed_o && valid_word_count_o == 7'h00)
		else $error("arming did not clear count");
	AST_END_DISARM: assert property (
		end_hit |=> !armed_o)
		else $error("end trigger left unit armed");
	AST_END_BRK: assert property (
		end_hit && ab_breakpoint_enable_i
		|=> brk_req_o && brk_tagged_o == $past(trigger_select_i))
		else $error("end trigger breakpoint wrong");
	AST_C_BRK: assert property (
		run && comp_c_match_i && c_breakpoint_enable_i && capture_mode_i != 2'h1 && !trigger_i
		|=> brk_req_o && brk_tagged_o == $past(c_breakpoint_type_i))
		else $error("comparator C breakpoint wrong");
	// Armed end runs count too; only a full begin run could break here
	AST_C_OFF_LOOP: assert property (
		run && capture_mode_i == 2'h1 && comp_c_match_i && !trigger_i
		&& !(armed_o && (begin_sel_i || event_only_i)) |=> !brk_req_o)
		else $error("comparator C breakpoint in loop mode");
	COV_FORCED: cover property (brk_req_o && !brk_tagged_o);
	COV_TAGGED: cover property (brk_req_o && brk_tagged_o);
	COV_READ: cover property (trace_data_valid_o);
endmodule : tcbu_checker
bind tcbu_top tcbu_checker chk_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
	.debug_enable_i(debug_enable_i), .arm_i(arm_i), .begin_sel_i(begin_sel_i),
	.event_only_i(event_only_i), .capture_mode_i(capture_mode_i),
	.trigger_select_i(trigger_select_i), .ab_breakpoint_enable_i(ab_breakpoint_enable_i),
	.c_breakpoint_enable_i(c_breakpoint_enable_i), .c_breakpoint_type_i(c_breakpoint_type_i),
	.trigger_i(trigger_i), .comp_c_match_i(comp_c_match_i), .trace_read_i(trace_read_i),
	.armed_o(armed_o), .valid_word_count_o(valid_word_count_o),
	.trace_data_valid_o(trace_data_valid_o), .brk_req_o(brk_req_o), .brk_tagged_o(brk_tagged_o));
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench of the trace capture and breakpoint unit
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        clk = 1'b0, rst_n = 1'b0, en = 1'b0, arm = 1'b0, dis = 1'b0, bsel = 1'b0;
	logic        tsel = 1'b0, abe = 1'b0, ce = 1'b0, ct = 1'b0, trig = 1'b0, cm = 1'b0;
	logic        rd = 1'b0, thi = 1'b0, req = 1'b0, software_interrupt = 1'b0, seen = 1'b0, stag = 1'b0;
	logic        ev = 1'b0;
	logic [1:0]  mode = 2'h0, kind = 2'h0;
	logic [15:0] a = 16'h0000, last = 16'h0000;
	logic        armed, tval, rdy, cign, brk, btag;
	logic [6:0]  cnt;
	logic [15:0] tdat, caddr;
	int          err_count = 0, checked = 0, cycles = 0;
	tcbu_pkg::tcbu_cycle_s cyc = '0;
	tcbu_pkg::tcbu_cof_s   cof;
	always #10 clk = ~clk;
	always @(posedge clk) if (brk) begin seen <= 1'b1; stag <= btag; end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			final_report();
		end
	end
	tcbu_cpu_model cpu (.sys_clk_i(clk), .req_i(req), .kind_i(kind), .swi_i(software_interrupt), .addr_i(a),
		.ready_i(rdy), .cof_o(cof));
	tcbu_top dut (.sys_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1), .debug_enable_i(en),
		.arm_i(arm), .disarm_i(dis), .begin_sel_i(bsel), .event_only_i(ev),
		.capture_mode_i(mode), .trigger_select_i(tsel), .ab_breakpoint_enable_i(abe),
		.c_breakpoint_enable_i(ce), .c_breakpoint_type_i(ct), .trigger_i(trig),
		.comp_c_match_i(cm), .cof_i(cof), .cycle_i(cyc), .last_instr_addr_i(last),
		.trace_read_i(rd), .ext_tag_high_pin_i(thi), .ext_tag_low_pin_i(1'b0),
		.armed_o(armed), .valid_word_count_o(cnt), .trace_data_o(tdat),
		.trace_data_valid_o(tval), .capture_ready_o(rdy), .comp_c_addr_o(caddr),
		.comp_c_ignore_o(cign), .brk_req_o(brk), .brk_tagged_o(btag));
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic send(input logic [1:0] k, input logic s, input logic [15:0] ad);
		kind = k;
		software_interrupt = s;
		a = ad;
		req = 1'b1;
		step();
		req = 1'b0;
		step(5);
	endtask : send
	task automatic bus(input logic [1:0] c, input logic [15:0] ad, input logic [15:0] d);
		cyc = {1'b1, c, ad, d};
		step();
		cyc = {1'b0, c, ~ad, ~d};
		step(5);
	endtask : bus
	task automatic pulse(ref logic s);
		s = 1'b1;
		step();
		s = 1'b0;
		step(3);
	endtask : pulse
	task automatic run(input logic [1:0] m, input logic b);
		mode = m;
		bsel = b;
		seen = 1'b0;
		pulse(arm);
	endtask : run
	task automatic rdchk(input logic [15:0] exp);
		rd = 1'b1;
		step();
		rd = 1'b0;
		chk(16'(tval), 16'h0001, "read valid");
		chk(tdat, exp, "read data");
		step();
	endtask : rdchk
	task automatic done(input string n);
		$display("test %s finished, %0d mismatches so far", n, err_count);
	endtask : done
	// The record reaches the unit one edge after the request, so the trigger rises then
	task automatic cof_trig(input logic [15:0] ad);
		kind = 2'h0;
		software_interrupt = 1'b0;
		a = ad;
		req = 1'b1;
		step();
		req = 1'b0;
		trig = 1'b1;
		step();
		trig = 1'b0;
		step(3);
	endtask : cof_trig
	task automatic t_end();
		en = 1'b1;
		abe = 1'b1;
		tsel = 1'b1;
		run(2'h0, 1'b0);
		send(2'h0, 1'b0, 16'h1000);
		send(2'h1, 1'b0, 16'h2000);
		send(2'h2, 1'b1, 16'h3000);
		send(2'h2, 1'b0, 16'h4000);
		cof_trig(16'h5000);
		chk(16'(armed), 16'h0000, "end disarm");
		chk(16'({seen, stag}), 16'h0003, "tagged end break");
		chk(16'(cnt), 16'h0003, "cof count");
		rdchk(16'h1000);
		rdchk(16'h2000);
		rdchk(16'h4000);
		chk(16'(cnt), 16'h0003, "count after read");
		run(2'h0, 1'b0);
		rd = 1'b1;
		step();
		rd = 1'b0;
		chk({15'h0000, tval}, 16'h0000, "armed read");
		pulse(dis);
		done("end trigger");
	endtask : t_end
	task automatic t_loop();
		ce = 1'b1;
		run(2'h1, 1'b0);
		send(2'h0, 1'b0, 16'h1234);
		send(2'h0, 1'b0, 16'h1234);
		send(2'h1, 1'b0, 16'h5678);
		send(2'h1, 1'b0, 16'h5678);
		chk(16'(cnt), 16'h0003, "loop count");
		chk({cign, caddr[14:0]}, 16'hd678, "comparator copy");
		pulse(cm);
		chk(16'(seen), 16'h0000, "no C break in loop");
		pulse(dis);
		run(2'h1, 1'b0);
		chk({cign, caddr[14:0]}, 16'h0000, "comparator cleared");
		pulse(dis);
		done("loop");
	endtask : t_loop
	task automatic t_detail();
		run(2'h2, 1'b0);
		bus(2'h0, 16'habcd, 16'h1357);
		bus(2'h1, 16'h1111, 16'h2222);
		bus(2'h2, 16'h3333, 16'h4444);
		chk(16'(cnt), 16'h0002, "detail count");
		pulse(dis);
		rdchk(16'habcd);
		rdchk(16'h1357);
		done("detail");
	endtask : t_detail
	task automatic t_begin();
		run(2'h0, 1'b1);
		send(2'h0, 1'b0, 16'h0777);
		chk(16'(cnt), 16'h0000, "nothing before trigger");
		cof_trig(16'h0abc);
		for (int i = 0; i < 70; i++) begin
			send(2'h0, 1'b0, 16'(i));
			if (i == 10) chk(16'(seen), 16'h0000, "no early break");
		end
		chk({armed, 8'h00, cnt}, 16'h0040, "full buffer");
		chk(16'({seen, stag}), 16'h0002, "forced full break");
		rdchk(16'h0abc);
		rdchk(16'h0000);
		done("begin trigger");
	endtask : t_begin
	task automatic t_cbrk();
		mode = 2'h0;
		ct = 1'b1;
		seen = 1'b0;
		pulse(cm);
		chk(16'({seen, stag, armed}), 16'h0006, "C break");
		seen = 1'b0;
		thi = 1'b1;
		step(6);
		thi = 1'b0;
		step(3);
		chk(16'(seen), 16'h0000, "tag pin ignored");
		done("comparator C");
	endtask : t_cbrk
	// End trigger is selected but must not apply: the run stays armed after each event
	task automatic t_event();
		ev = 1'b1;
		cyc = {1'b0, 2'h0, 16'h0000, 16'h5a5a};
		run(2'h0, 1'b0);
		pulse(trig);
		cyc = {1'b0, 2'h0, 16'h0000, 16'h6b6b};
		pulse(trig);
		chk(16'(armed), 16'h0001, "event-only stays armed");
		pulse(dis);
		ev = 1'b0;
		chk(16'(cnt), 16'h0002, "event word count");
		rdchk(16'h5a5a);
		rdchk(16'h6b6b);
		done("event only");
	endtask : t_event
	task automatic t_profile();
		mode = 2'h3;
		last = 16'hbeef;
		step();
		rdchk(16'hbeef);
		send(2'h0, 1'b0, 16'h0999);
		run(2'h3, 1'b0);
		pulse(trig);
		chk(16'({seen, armed}), 16'h0000, "profile idle");
		chk(16'(cnt), 16'h0002, "profile keeps count");
		done("profile");
	endtask : t_profile
	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	initial begin
		step(4);
		rst_n = 1'b1;
		step(2);
		chk({armed, 8'h00, cnt}, 16'h0000, "reset state");
		t_end();
		t_loop();
		t_detail();
		t_begin();
		t_cbrk();
		t_event();
		t_profile();
		final_report();
	end
endmodule : tb
`default_nettype wire
